// ---- bench/brs_assertions.sv ----
// Purpose: Port-level checks of per-character status coding
// Assumes: Mode pins steady for three edges before a mode check applies
// Notes:   State-dependent codes are left to the bench scenarios
`timescale 1ns/10ps
module brs_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] rx_config_select,
  input wire logic       char_valid,
  input wire logic [7:0] char_data,
  input wire logic       char_special,
  input wire logic       code_violation,
  input wire logic       disparity_error,
  input wire logic       buffer_error,
  input wire logic       pll_unlock,
  input wire logic       rx_out_valid,
  input wire logic [7:0] rx_data_out,
  input wire logic [2:0] rx_char_status_code
);
  import brs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] cfg_d1;
  logic [1:0] cfg_d2;
  logic [1:0] age;
  logic       indep;
  logic       clean;
  // Pins pass a two-flop synchroniser, so a mode is trusted only once settled
  always_ff @(posedge aclk) begin
    cfg_d1 <= rx_config_select;
    cfg_d2 <= cfg_d1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  assign indep = (age == 2'h3) && (rx_config_select == cfg_d1) && (cfg_d1 == cfg_d2);
  assign clean = !buffer_error && !pll_unlock;
  a_out_pulse: assert property (char_valid |=> rx_out_valid) else $error("no output strobe");
  a_out_idle: assert property (!char_valid |=> !rx_out_valid) else $error("stray output strobe");
  a_hold_quiet: assert property (!rx_out_valid |-> $stable(rx_data_out) && $stable(rx_char_status_code))
    else $error("output changed between characters");
  a_pll_wins: assert property (char_valid && pll_unlock |=> rx_char_status_code == BRS_ST_LOSS)
    else $error("pll unlock not reported");
  a_viol_sub: assert property (indep && !cfg_d2[1] && char_valid && code_violation && clean
    |=> rx_char_status_code == BRS_ST_VIOL && rx_data_out == BRS_CHAR_C07) else $error("violation coding");
  a_disp_pass: assert property (indep && !cfg_d2[1] && char_valid && disparity_error && !code_violation && clean
    |=> rx_char_status_code == BRS_ST_DISP && rx_data_out == $past(char_data)) else $error("disparity coding");
  a_frame_code: assert property (indep && !cfg_d2[1] && char_valid && char_special && char_data == BRS_CHAR_K285
    && !code_violation && !disparity_error && clean |=> rx_char_status_code == BRS_ST_FRAMING)
    else $error("framing coding");
  a_buf_a: assert property (indep && cfg_d2 == 2'b00 && char_valid && buffer_error && !pll_unlock
    |=> rx_char_status_code == BRS_ST_BUF_LCK) else $error("variant A buffer coding");
  a_buf_b: assert property (indep && cfg_d2[0] && char_valid && buffer_error
    |=> rx_char_status_code == BRS_ST_LOSS) else $error("variant B buffer coding");
  a_data_plain: assert property (indep && !cfg_d2[1] && char_valid && !char_special && !code_violation
    && !disparity_error && clean |=> rx_char_status_code == BRS_ST_DATA && rx_data_out == $past(char_data))
    else $error("data coding");
endmodule

bind brs_top brs_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .rx_config_select(rx_config_select), .char_valid(char_valid),
  .char_data(char_data), .char_special(char_special), .code_violation(code_violation),
  .disparity_error(disparity_error), .buffer_error(buffer_error), .pll_unlock(pll_unlock),
  .rx_out_valid(rx_out_valid), .rx_data_out(rx_data_out), .rx_char_status_code(rx_char_status_code)
);

// ---- bench/brs_host_model.sv ----
// Purpose: Host logic that takes each character off the output bus
// Assumes: One strobe per character, no back pressure
// Notes:   The count lets the bench spot lost or doubled characters
`timescale 1ns/10ps
module brs_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_out_valid,
  output int       n_seen
);
  always_ff @(posedge aclk) begin
    if (!aresetn) n_seen <= 0;
    else if (rx_out_valid) n_seen <= n_seen + 1;
  end
endmodule

// ---- bench/test_bonded_rx_sync_status.sv ----
// Purpose: Self-checking bench for bonded receive status coding
// Assumes: Mode pins settle within four edges
// Notes:   Transition characters with unsettled codes are not checked
`timescale 1ns/10ps
module test_bonded_rx_sync_status;
  import brs_pkg::*;
  typedef struct packed {logic [1:0] cfg; logic [7:0] d; logic [6:0] f; logic [2:0] ec;} brs_row_s;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [1:0]  rx_config_select = 2'b00;
  logic        char_valid = 1'b0;
  logic [7:0]  char_data = 8'h00;
  logic [6:0]  flg = 7'h00;
  logic        rx_out_valid;
  logic [7:0]  rx_data_out;
  logic [2:0]  rx_char_status_code;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  rr;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        inh = 1'b0, fsel = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_fail = 0, n_compared = 0, n_sent = 0, n_seen;
  // Flag bits: special, violation, disparity, buffer, pll, deskew, lock
  brs_row_s rows [12] = '{'{2'b00, 8'h55, 7'h00, BRS_ST_DATA}, '{2'b00, 8'h1C, 7'h40, BRS_ST_SPECIAL},
    '{2'b00, 8'hBC, 7'h40, BRS_ST_FRAMING}, '{2'b00, 8'hAA, 7'h20, BRS_ST_VIOL},
    '{2'b00, 8'hAA, 7'h30, BRS_ST_VIOL}, '{2'b00, 8'h77, 7'h10, BRS_ST_DISP},
    '{2'b00, 8'h55, 7'h08, BRS_ST_BUF_LCK}, '{2'b00, 8'hAA, 7'h28, BRS_ST_BUF_LCK},
    '{2'b00, 8'h55, 7'h0C, BRS_ST_LOSS}, '{2'b01, 8'h55, 7'h08, BRS_ST_LOSS},
    '{2'b01, 8'h55, 7'h04, BRS_ST_LOSS}, '{2'b01, 8'h55, 7'h00, BRS_ST_DATA}};
  always #50 aclk = ~aclk;
  brs_top dut (.aclk(aclk), .aresetn(aresetn), .rx_config_select(rx_config_select), .bond_inhibit(inh),
    .framing_pattern_select(fsel), .char_valid(char_valid), .char_data(char_data), .char_special(flg[6]),
    .code_violation(flg[5]), .disparity_error(flg[4]), .buffer_error(flg[3]), .pll_unlock(flg[2]),
    .deskew_expired(flg[1]), .channel_lock(flg[0]), .rx_out_valid(rx_out_valid), .rx_data_out(rx_data_out),
    .rx_char_status_code(rx_char_status_code), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready));
  brs_host_model u_host (.aclk(aclk), .aresetn(aresetn), .rx_out_valid(rx_out_valid), .n_seen(n_seen));
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task automatic chr(input logic [7:0] d, input logic [6:0] f, input logic ck, input logic [2:0] ec);
    @(posedge aclk);
    char_valid <= 1'b1;
    char_data <= d;
    flg <= f;
    @(posedge aclk);
    char_valid <= 1'b0;
    flg <= 7'h00;
    n_sent++;
    @(negedge aclk);
    cmp("out_valid", 32'h1, 32'(rx_out_valid));
    if (ck) cmp("status", 32'(ec), 32'(rx_char_status_code));
    // Data under loss or buffer/pll faults is not defined, so it is skipped
    if (ck && f[3:2] == 2'b00 && ec != BRS_ST_LOSS) cmp("data", 32'(f[5] ? BRS_CHAR_C07 : d), 32'(rx_data_out));
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  // Pins change on a rising edge and get three more edges to pass the synchroniser
  task automatic set_cfg(input logic [1:0] c, input logic [1:0] p);
    @(posedge aclk);
    rx_config_select <= c;
    {inh, fsel} <= p;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp("reset_status", 32'(BRS_ST_LOSS), 32'(rx_char_status_code));
    cmp("reset_awready", 32'h1, 32'(awready));
    foreach (rows[i]) begin
      set_cfg(rows[i].cfg, 2'b00);
      chr(rows[i].d, rows[i].f, 1'b1, rows[i].ec);
    end
    chr(8'h3C, 7'h40, 1'b1, BRS_ST_SPECIAL);
    set_cfg(2'b00, 2'b01);
    chr(8'h3C, 7'h40, 1'b1, BRS_ST_FRAMING);
    chr(8'hFC, 7'h40, 1'b1, BRS_ST_FRAMING);
    chr(8'h1C, 7'h40, 1'b1, BRS_ST_SPECIAL);
    set_cfg(2'b10, 2'b00);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    repeat (2) chr(8'hBC, 7'h40, 1'b1, BRS_ST_RESYNC);
    chr(8'hBC, 7'h40, 1'b0, BRS_ST_DATA);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_DATA);
    axi_rd(BRS_OFF_STATE, rd, rr);
    cmp("state_locked", 32'h24, rd & 32'h3F);
    repeat (3) chr(8'hAA, 7'h20, 1'b1, BRS_ST_VIOL);
    chr(8'hAA, 7'h20, 1'b1, BRS_ST_LOSS);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_LOSS);
    axi_rd(BRS_OFF_LOSSCNT, rd, rr);
    cmp("loss_count", 32'h1, rd);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    chr(8'h55, 7'h00, 1'b0, BRS_ST_DATA);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_DATA);
    chr(8'h55, 7'h08, 1'b1, BRS_ST_LOSS);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    chr(8'h55, 7'h02, 1'b0, BRS_ST_DATA);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_LOSS);
    axi_rd(BRS_OFF_STATE, rd, rr);
    cmp("state_failed", 32'h8, rd & 32'hF);
    chr(8'h55, 7'h04, 1'b1, BRS_ST_LOSS);
    set_cfg(2'b10, 2'b10);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    chr(8'hBC, 7'h42, 1'b1, BRS_ST_RESYNC);
    chr(8'hAA, 7'h20, 1'b1, BRS_ST_RESYNC);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    chr(8'hAA, 7'h20, 1'b0, BRS_ST_DATA);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    set_cfg(2'b11, 2'b00);
    chr(8'h55, 7'h08, 1'b1, BRS_ST_LOSS);
    chr(8'hBC, 7'h40, 1'b1, BRS_ST_LOSS);
    chr(8'hBC, 7'h41, 1'b1, BRS_ST_BUF_LCK);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_DATA);
    axi_wr(BRS_OFF_CTRL, 32'h3, rr);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_LOSS);
    axi_wr(BRS_OFF_CTRL, 32'h0, rr);
    cmp("ctrl_bresp", 32'(BRS_RESP_OKAY), 32'(rr));
    chr(8'h55, 7'h08, 1'b1, BRS_ST_LOSS);
    chr(8'h55, 7'h00, 1'b1, BRS_ST_DATA);
    axi_wr(BRS_OFF_CTRL, 32'h1, rr);
    axi_wr(BRS_OFF_LOSSCNT, 32'h0, rr);
    axi_rd(BRS_OFF_LOSSCNT, rd, rr);
    cmp("loss_clear", 32'h0, rd);
    axi_rd(12'h010, rd, rr);
    cmp("unmapped_rresp", 32'(BRS_RESP_DECERR), 32'(rr));
    cmp("unmapped_rdata", 32'h0, rd);
    axi_wr(12'h010, 32'h1, rr);
    cmp("unmapped_bresp", 32'(BRS_RESP_DECERR), 32'(rr));
    cmp("chars_seen", 32'(n_sent), 32'(n_seen));
    // Second reset in mid-run; the host count restarts, so it was checked above
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp("rst2_status", 32'(BRS_ST_LOSS), 32'(rx_char_status_code));
    cmp("rst2_data", 32'h0, 32'(rx_data_out));
    axi_rd(BRS_OFF_STATE, rd, rr);
    cmp("rst2_state", 32'h1, rd & 32'hF);
    close_out();
  end
endmodule

// ---- common/brs_pkg.sv ----
// Function
// - Bonded channel runs four-state sync machine
// - Valid data character reports code 000
// - Valid non-framing special character reports 001
// - Variant A: buffer add/drop failure reports 010
// - Variant B: channel lock 010 before alignment
// - Framing pattern match reports 011 with data
// - Undecodable character reports 100 with C0.7
// - Loss of sync or alignment reports 101
// - Variant B: PLL unlock independent reports 101
// - Variant B: buffer under/overflow reports 101
// - Disparity error reports 110 with decoder data
// - Realigning reports 111 with framing character
// - Deskew expiry, bond inhibit low: bonding fails
// - Buffer or PLL error: lose sync; decoder error does too while realigning
// - Four consecutive framing characters reach lock
// - Four consecutive decoder errors leave lock
// - Invalid minus valid reaching four leaves lock
// - Valid non-framing character reaches lock
// - Machine runs only when channels bonded
// Purpose: Constants shared by the bonded receive sync status block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   Status codes are the 3-bit per-character codes
package brs_pkg;

  localparam logic [2:0] BRS_ST_DATA    = 3'h0;
  localparam logic [2:0] BRS_ST_SPECIAL = 3'h1;
  localparam logic [2:0] BRS_ST_BUF_LCK = 3'h2;
  localparam logic [2:0] BRS_ST_FRAMING = 3'h3;
  localparam logic [2:0] BRS_ST_VIOL    = 3'h4;
  localparam logic [2:0] BRS_ST_LOSS    = 3'h5;
  localparam logic [2:0] BRS_ST_DISP    = 3'h6;
  localparam logic [2:0] BRS_ST_RESYNC  = 3'h7;

  // Replacement character C0.7 and the comma-class special characters
  localparam logic [7:0] BRS_CHAR_C07   = 8'hE0;
  localparam logic [7:0] BRS_CHAR_K285  = 8'hBC;
  localparam logic [7:0] BRS_CHAR_K281  = 8'h3C;
  localparam logic [7:0] BRS_CHAR_K287  = 8'hFC;

  localparam logic [2:0] BRS_FRAME_COUNT = 3'h4;
  localparam logic [2:0] BRS_ERR_COUNT   = 3'h4;
  localparam logic [2:0] BRS_IMV_LIMIT   = 3'h4;

  localparam logic [11:0] BRS_OFF_CTRL    = 12'h000;
  localparam logic [11:0] BRS_OFF_STATE   = 12'h004;
  localparam logic [11:0] BRS_OFF_LOSSCNT = 12'h008;
  localparam logic [11:0] BRS_OFF_CHARCNT = 12'h00C;

  localparam logic [1:0]  BRS_CTRL_RESET  = 2'h1;
  localparam logic [15:0] BRS_CNT_RESET   = 16'h0000;

  localparam logic [1:0] BRS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BRS_RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    st_unsync            = 4'h1,
    st_realign           = 4'h2,
    st_locked            = 4'h4,
    bonding_failed_state = 4'h8
  } brs_state_e;

endpackage

// ---- rtl/brs_sync.sv ----
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are slow levels relative to aclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module brs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ---- rtl/brs_top.sv ----
// Purpose: Per-channel bonded receive synchronisation and status coding
// Assumes: Decoder flags arrive on aclk, qualified by char_valid
// Notes:   Mode, inhibit and framing select are pins and get synchronised
`timescale 1ns/10ps
module brs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  rx_config_select,
  input  wire logic        bond_inhibit,
  input  wire logic        framing_pattern_select,
  input  wire logic        char_valid,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_special,
  input  wire logic        code_violation,
  input  wire logic        disparity_error,
  input  wire logic        buffer_error,
  input  wire logic        pll_unlock,
  input  wire logic        deskew_expired,
  input  wire logic        channel_lock,
  output logic             rx_out_valid,
  output logic [7:0]       rx_data_out,
  output logic [2:0]       rx_char_status_code,
  input  wire logic [11:0] s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [11:0] s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready
);
  import brs_pkg::*;

  // Lowest priority number first: 101,010,111,100,011,110,001,000
  function automatic logic [2:0] brs_pick(input logic [7:0] cand);
    logic [2:0] code;
    code = BRS_ST_DATA;
    if (cand[BRS_ST_LOSS])
      code = BRS_ST_LOSS;
    else if (cand[BRS_ST_BUF_LCK])
      code = BRS_ST_BUF_LCK;
    else if (cand[BRS_ST_RESYNC])
      code = BRS_ST_RESYNC;
    else if (cand[BRS_ST_VIOL])
      code = BRS_ST_VIOL;
    else if (cand[BRS_ST_FRAMING])
      code = BRS_ST_FRAMING;
    else if (cand[BRS_ST_DISP])
      code = BRS_ST_DISP;
    else if (cand[BRS_ST_SPECIAL])
      code = BRS_ST_SPECIAL;
    return code;
  endfunction

  // Saturating step used by both error counters
  function automatic logic [2:0] brs_inc(input logic [2:0] v);
    return (v == 3'h7) ? v : 3'(v + 3'h1);
  endfunction

  logic [3:0] pins_sync;
  logic       bonded;
  logic       variant_b;
  logic       inhibit_s;
  logic       frame_sel_s;

  brs_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({rx_config_select, bond_inhibit, framing_pattern_select}),
    .sync_out (pins_sync)
  );

  assign bonded      = pins_sync[3];
  assign variant_b   = pins_sync[2];
  assign inhibit_s   = pins_sync[1];
  assign frame_sel_s = pins_sync[0];

  // Register file state
  logic [1:0]  ctrl_reg;
  logic [15:0] loss_cnt_reg;
  logic [15:0] char_cnt_reg;
  logic        resync_pulse;

  // Character classification
  logic       is_framing;
  logic       dec_err;
  logic       loss_cond;
  logic       sync_en;
  logic       take;

  // Frame select 0 takes only K28.5, 1 takes any comma-class special
  always_comb begin
    is_framing = 1'b0;
    if (char_special && !code_violation && !disparity_error) begin
      if (!frame_sel_s)
        is_framing = (char_data == BRS_CHAR_K285);
      else
        is_framing = (char_data == BRS_CHAR_K285) || (char_data == BRS_CHAR_K281) ||
                     (char_data == BRS_CHAR_K287);
    end
  end

  assign dec_err   = code_violation | disparity_error;
  assign loss_cond = buffer_error | pll_unlock;
  assign sync_en   = bonded & ctrl_reg[0];
  assign take      = char_valid;

  brs_state_e state_reg;
  brs_state_e state_next;
  logic [2:0] frame_cnt_reg;
  logic [2:0] frame_cnt_next;
  logic [2:0] err_cnt_reg;
  logic [2:0] err_cnt_next;
  logic [2:0] imv_reg;
  logic [2:0] imv_next;

  // Next state, evaluated once per received character
  always_comb begin
    state_next     = state_reg;
    frame_cnt_next = frame_cnt_reg;
    err_cnt_next   = err_cnt_reg;
    imv_next       = imv_reg;
    unique case (state_reg)
      st_unsync: begin
        frame_cnt_next = 3'h0;
        err_cnt_next   = 3'h0;
        imv_next       = 3'h0;
        if (is_framing && !loss_cond) begin
          state_next     = st_realign;
          frame_cnt_next = 3'h1;
        end
      end
      st_realign: begin
        if (loss_cond || dec_err) begin
          state_next = st_unsync;
        end else if (!inhibit_s && deskew_expired) begin
          state_next = bonding_failed_state;
        end else if (variant_b) begin
          if (channel_lock)
            state_next = st_locked;
        end else if (is_framing) begin
          frame_cnt_next = brs_inc(frame_cnt_reg);
          if (brs_inc(frame_cnt_reg) >= BRS_FRAME_COUNT)
            state_next = st_locked;
        end else begin
          state_next = st_locked;
        end
        if (state_next == st_locked) begin
          err_cnt_next = 3'h0;
          imv_next     = 3'h0;
        end
      end
      st_locked: begin
        if (dec_err) begin
          err_cnt_next = brs_inc(err_cnt_reg);
          imv_next     = brs_inc(imv_reg);
        end else begin
          err_cnt_next = 3'h0;
          imv_next     = (imv_reg == 3'h0) ? imv_reg : 3'(imv_reg - 3'h1);
        end
        if (loss_cond ||
            (err_cnt_next >= BRS_ERR_COUNT) ||
            (imv_next >= BRS_IMV_LIMIT))
          state_next = st_unsync;
      end
      bonding_failed_state: begin
        if (loss_cond)
          state_next = st_unsync;
      end
    endcase
  end

  // Sync machine: held unsynchronised while not bonded or not enabled, or on soft resync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= st_unsync;
      frame_cnt_reg <= 3'h0;
      err_cnt_reg   <= 3'h0;
      imv_reg       <= 3'h0;
    end else if (!sync_en || resync_pulse) begin
      state_reg     <= st_unsync;
      frame_cnt_reg <= 3'h0;
      err_cnt_reg   <= 3'h0;
      imv_reg       <= 3'h0;
    end else if (take) begin
      state_reg     <= state_next;
      frame_cnt_reg <= frame_cnt_next;
      err_cnt_reg   <= err_cnt_next;
      imv_reg       <= imv_next;
    end
  end

  // Candidate codes for the character in hand
  logic [7:0] cand;
  logic [2:0] code_next;
  logic [7:0] data_next;

  always_comb begin
    cand = 8'h00;
    if (code_violation)
      cand[BRS_ST_VIOL] = 1'b1;
    else if (disparity_error)
      cand[BRS_ST_DISP] = 1'b1;
    else if (is_framing)
      cand[BRS_ST_FRAMING] = 1'b1;
    else if (char_special)
      cand[BRS_ST_SPECIAL] = 1'b1;
    else
      cand[BRS_ST_DATA] = 1'b1;
    if (!sync_en) begin
      cand[BRS_ST_LOSS] = pll_unlock;
      if (variant_b)
        cand[BRS_ST_LOSS] = pll_unlock | buffer_error;
      else
        cand[BRS_ST_BUF_LCK] = buffer_error;
    end else begin
      if (variant_b)
        cand[BRS_ST_LOSS] = buffer_error | pll_unlock;
      else begin
        cand[BRS_ST_BUF_LCK] = buffer_error;
        cand[BRS_ST_LOSS]    = pll_unlock;
      end
      unique case (state_reg)
        st_unsync:
          cand[BRS_ST_LOSS] = 1'b1;
        st_realign: begin
          cand[BRS_ST_RESYNC] = 1'b1;
          if (variant_b && state_next == st_locked)
            cand[BRS_ST_BUF_LCK] = 1'b1;
        end
        st_locked:
          if (state_next == st_unsync)
            cand[BRS_ST_LOSS] = 1'b1;
        bonding_failed_state:
          cand[BRS_ST_LOSS] = 1'b1;
      endcase
    end
    code_next = brs_pick(cand);
    data_next = code_violation ? BRS_CHAR_C07 : char_data;
  end

  // Output register, one entry per character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_out_valid        <= 1'b0;
      rx_data_out         <= 8'h00;
      rx_char_status_code <= BRS_ST_LOSS;
    end else begin
      rx_out_valid <= take;
      if (take) begin
        rx_data_out         <= data_next;
        rx_char_status_code <= code_next;
      end
    end
  end

  // Statistics; a counting event in the clearing cycle survives as one
  logic lost_lock;
  assign lost_lock = take && sync_en && !resync_pulse &&
                     (state_reg == st_locked) && (state_next == st_unsync);

  // AXI4-Lite write side: address and data may arrive in either order
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;

  assign s_axil_awready = !aw_got_reg;
  assign s_axil_wready  = !w_got_reg;
  assign do_write       = aw_got_reg && w_got_reg && !s_axil_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axil_awaddr;
      end else if (s_axil_bvalid && s_axil_bready) begin
        aw_got_reg <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axil_wdata;
        wstrb_reg <= s_axil_wstrb;
      end else if (s_axil_bvalid && s_axil_bready) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  logic wr_ctrl;
  logic wr_loss;
  logic wr_known;
  assign wr_ctrl  = do_write && (awaddr_reg[11:2] == BRS_OFF_CTRL[11:2]);
  assign wr_loss  = do_write && (awaddr_reg[11:2] == BRS_OFF_LOSSCNT[11:2]);
  assign wr_known = (awaddr_reg[11:2] == BRS_OFF_CTRL[11:2]) ||
                    (awaddr_reg[11:2] == BRS_OFF_STATE[11:2]) ||
                    (awaddr_reg[11:2] == BRS_OFF_LOSSCNT[11:2]) ||
                    (awaddr_reg[11:2] == BRS_OFF_CHARCNT[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= BRS_RESP_OKAY;
    end else if (do_write) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp  <= wr_known ? BRS_RESP_OKAY : BRS_RESP_DECERR;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Resync is write-one, self-clearing; enable bit is plain storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= BRS_CTRL_RESET;
      resync_pulse <= 1'b0;
    end else begin
      resync_pulse <= wr_ctrl && wstrb_reg[0] && wdata_reg[1];
      if (wr_ctrl && wstrb_reg[0])
        ctrl_reg <= {1'b0, wdata_reg[0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_cnt_reg <= BRS_CNT_RESET;
    end else if (wr_loss) begin
      loss_cnt_reg <= lost_lock ? 16'h0001 : BRS_CNT_RESET;
    end else if (lost_lock && loss_cnt_reg != 16'hFFFF) begin
      loss_cnt_reg <= 16'(loss_cnt_reg + 16'h0001);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      char_cnt_reg <= BRS_CNT_RESET;
    end else if (take) begin
      char_cnt_reg <= 16'(char_cnt_reg + 16'h0001);
    end
  end

  // AXI4-Lite read side: answer one cycle after the address is taken
  logic [31:0] rd_word;
  logic        rd_known;

  always_comb begin
    rd_word  = 32'h00000000;
    rd_known = 1'b1;
    if (s_axil_araddr[11:2] == BRS_OFF_CTRL[11:2])
      rd_word = {30'h0000000, ctrl_reg};
    else if (s_axil_araddr[11:2] == BRS_OFF_STATE[11:2])
      rd_word = {21'h00000, rx_char_status_code, 2'h0, bonded, variant_b, state_reg};
    else if (s_axil_araddr[11:2] == BRS_OFF_LOSSCNT[11:2])
      rd_word = {16'h0000, loss_cnt_reg};
    else if (s_axil_araddr[11:2] == BRS_OFF_CHARCNT[11:2])
      rd_word = {16'h0000, char_cnt_reg};
    else
      rd_known = 1'b0;
  end

  assign s_axil_arready = !s_axil_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h00000000;
      s_axil_rresp  <= BRS_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata  <= rd_word;
      s_axil_rresp  <= rd_known ? BRS_RESP_OKAY : BRS_RESP_DECERR;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

endmodule
